// File: rtl/psc_defs.vh
// constants for the protection switch control block
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

// register byte offsets
`define PSC_OFS_CTRL     4'h0
`define PSC_OFS_CMD      4'h4
`define PSC_OFS_TIME     4'h8
`define PSC_OFS_STATUS   4'hC

// control register field positions
`define PSC_CTRL_AUTO    0
`define PSC_CTRL_ARET    1
`define PSC_CTRL_SDET    2
`define PSC_CTRL_PMODE   3
`define PSC_CTRL_SMODE   5

// command register bits (write one to act)
`define PSC_CMD_PRI      0
`define PSC_CMD_SEC      1
`define PSC_CMD_AUTOTGL  2

// timing register field positions
`define PSC_TIME_FAIL    0
`define PSC_TIME_RESET   8

// status register field positions
`define PSC_ST_POS       0
`define PSC_ST_PSTAT     1
`define PSC_ST_SSTAT     3
`define PSC_ST_PTRIG     5
`define PSC_ST_STRIG     7

// reset values: auto on, auto return on, detect on, trigger modes off
`define PSC_CTRL_RST     8'h07
`define PSC_FAIL_RST     8'h03
`define PSC_RESET_RST    8'h0F

// trigger modes
`define PSC_MODE_OFF     2'h0
`define PSC_MODE_EDGE    2'h1
`define PSC_MODE_EXTLOW  2'h2

// overall status codes
`define PSC_OV_GOOD      2'h0
`define PSC_OV_BAD       2'h1
`define PSC_OV_NONE      2'h2

// trigger status codes
`define PSC_TS_GOOD      2'h0
`define PSC_TS_DETFAIL   2'h1
`define PSC_TS_EXTFAIL   2'h2
`define PSC_TS_BOTHFAIL  2'h3

// timing: clock rate and the one second tick
`define PSC_CLK_HZ       50000000
`define PSC_TICK_SEC     1
`define PSC_TICK_CYC     (`PSC_CLK_HZ * `PSC_TICK_SEC)

`endif

// File: rtl/psc_protection_switch_control.v
// protection switch decision logic with an avalon-mm register slave
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`include "psc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module psc_protection_switch_control
#(
    parameter integer TICK_CYCLES = `PSC_TICK_CYC
)
(
    input  wire        clk,
    input  wire        resetn,
    input  wire [3:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWriteData,
    input  wire [3:0]  avsByteEnable,
    output reg  [31:0] avsReadData,
    output wire        avsWaitRequest,
    input  wire        priSigOk,
    input  wire        secSigOk,
    input  wire        priTrigIn,
    input  wire        secTrigIn,
    output wire        selSecondary,
    output wire        priLedGreen,
    output wire        secLedRed,
    output wire        autoLedGreen,
    output wire [1:0]  priOverall,
    output wire [1:0]  secOverall,
    output wire [1:0]  priTrigStatus,
    output wire [1:0]  secTrigStatus
);

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    reg  [7:0]  ctrl_r;
    reg  [7:0]  failTime_r;
    reg  [7:0]  resetTime_r;
    reg         ack_r;
    reg         cmdPri_r;
    reg         cmdSec_r;
    wire        wrHit;
    wire        rdHit;
    wire [31:0] statusWord;

    // register map, one 32-bit word each:
    //   control - auto, auto return, detect, primary and secondary trigger modes
    //   command - write-one pulses: select primary, select secondary, toggle auto
    //   timing  - fail seconds in the low byte, hold seconds in the next byte
    //   status  - position, overall and trigger status of both channels
    // one wait cycle per access keeps read data registered; the cost is
    // half the bus rate, which a settings port never notices
    assign wrHit          = avsWrite & ~ack_r;
    assign rdHit          = avsRead & ~ack_r;
    assign avsWaitRequest = (avsRead | avsWrite) & ~ack_r;

    // register writes take effect in the cycle the request is first seen
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r      <= `PSC_CTRL_RST;
            failTime_r  <= `PSC_FAIL_RST;
            resetTime_r <= `PSC_RESET_RST;
            ack_r       <= 1'b0;
            cmdPri_r    <= 1'b0;
            cmdSec_r    <= 1'b0;
        end
        else
        begin
            ack_r    <= (avsRead | avsWrite) & ~ack_r;
            cmdPri_r <= 1'b0;
            cmdSec_r <= 1'b0;
            if (wrHit && avsByteEnable[0])
            begin
                case (avsAddress)
                    `PSC_OFS_CTRL:
                        ctrl_r <= avsWriteData[7:0];
                    `PSC_OFS_CMD:
                    begin
                        cmdPri_r <= avsWriteData[`PSC_CMD_PRI];
                        cmdSec_r <= avsWriteData[`PSC_CMD_SEC];
                        if (avsWriteData[`PSC_CMD_AUTOTGL])
                            ctrl_r[`PSC_CTRL_AUTO] <= ~ctrl_r[`PSC_CTRL_AUTO];
                    end
                    `PSC_OFS_TIME:
                        failTime_r <= avsWriteData[7:0];
                    default:
                        ;
                endcase
            end
            if (wrHit && avsByteEnable[1] && avsAddress == `PSC_OFS_TIME)
                resetTime_r <= avsWriteData[15:8];
        end
    end

    // read data; unmapped addresses read zero
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            avsReadData <= 32'h0000_0000;
        else if (rdHit)
        begin
            case (avsAddress)
                `PSC_OFS_CTRL:   avsReadData <= {24'h00_0000, ctrl_r};
                `PSC_OFS_TIME:   avsReadData <= {16'h0000, resetTime_r, failTime_r};
                `PSC_OFS_STATUS: avsReadData <= statusWord;
                default:         avsReadData <= 32'h0000_0000;
            endcase
        end
    end

    wire       autoOn   = ctrl_r[`PSC_CTRL_AUTO];
    wire       aretOn   = ctrl_r[`PSC_CTRL_ARET];
    wire       sdetOn   = ctrl_r[`PSC_CTRL_SDET];
    wire [1:0] priMode  = ctrl_r[`PSC_CTRL_PMODE+1:`PSC_CTRL_PMODE];
    wire [1:0] secMode  = ctrl_r[`PSC_CTRL_SMODE+1:`PSC_CTRL_SMODE];

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers and trigger edges

    reg  [1:0] trigMeta_r;
    reg  [1:0] trigSync_r;
    reg  [1:0] trigLast_r;
    reg  [1:0] sigMeta_r;
    reg  [1:0] sigSync_r;

    // first stage feeds only the second; edge logic reads later stages
    // trigger flops reset high, the idle pin level, so reset makes no false edge
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            trigMeta_r <= 2'b11;
            trigSync_r <= 2'b11;
            trigLast_r <= 2'b11;
            sigMeta_r  <= 2'b00;
            sigSync_r  <= 2'b00;
        end
        else
        begin
            trigMeta_r <= {secTrigIn, priTrigIn};
            trigSync_r <= trigMeta_r;
            trigLast_r <= trigSync_r;
            sigMeta_r  <= {secSigOk, priSigOk};
            sigSync_r  <= sigMeta_r;
        end
    end

    // one pulse per physical fall, and only in edge mode
    wire priFall = trigLast_r[0] & ~trigSync_r[0] & (priMode == `PSC_MODE_EDGE);
    wire secFall = trigLast_r[1] & ~trigSync_r[1] & (secMode == `PSC_MODE_EDGE);

    ////////////////////////////////////////////////////////////////////////////
    // per-channel fault tests and status

    wire [1:0] detFail;
    wire [1:0] extFail;
    wire [1:0] chFault;
    wire [1:0] tstEnabled;
    wire [3:0] trigStat;
    wire [3:0] overall;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : gChan
            wire [1:0] mode    = (ch == 0) ? priMode : secMode;
            // code 3 is unused and decodes as off, so a stray value never switches
            wire       extMode = (mode == `PSC_MODE_EXTLOW);
            // detect verdict only counts while detection is on
            assign detFail[ch]    = sdetOn & ~sigSync_r[ch];
            // external check needs active-low mode; off mode never counts
            assign extFail[ch]    = extMode & ~trigSync_r[ch];
            assign chFault[ch]    = detFail[ch] | extFail[ch];
            assign tstEnabled[ch] = sdetOn | extMode;
            assign trigStat[2*ch+1:2*ch] =
                (detFail[ch] & extFail[ch]) ? `PSC_TS_BOTHFAIL :
                extFail[ch]                 ? `PSC_TS_EXTFAIL  :
                detFail[ch]                 ? `PSC_TS_DETFAIL  :
                                              `PSC_TS_GOOD;
            assign overall[2*ch+1:2*ch] =
                ~tstEnabled[ch] ? `PSC_OV_NONE :
                chFault[ch]     ? `PSC_OV_BAD  : `PSC_OV_GOOD;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // registered status outputs

    reg  [3:0] trigStat_r;
    reg  [3:0] overall_r;

    // status pins come from flops; the decode above may glitch as pins resolve
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            trigStat_r <= {`PSC_TS_GOOD, `PSC_TS_GOOD};
            overall_r  <= {`PSC_OV_GOOD, `PSC_OV_GOOD};
        end
        else
        begin
            trigStat_r <= trigStat;
            overall_r  <= overall;
        end
    end

    assign priTrigStatus = trigStat_r[1:0];
    assign secTrigStatus = trigStat_r[3:2];
    assign priOverall    = overall_r[1:0];
    assign secOverall    = overall_r[3:2];

    ////////////////////////////////////////////////////////////////////////////
    // one second tick

    reg  [31:0] tickCnt_r;
    wire        tick = (tickCnt_r == TICK_CYCLES - 1);

    // a single prescaler serves both timers; it trades sub-second accuracy for area
    // one tick every TICK_CYCLES clocks; each timer may run up to one tick short
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tickCnt_r <= 32'h0000_0000;
        else if (tick)
            tickCnt_r <= 32'h0000_0000;
        else
            tickCnt_r <= tickCnt_r + 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault persistence and recovery hold timers

    reg  [7:0] failSec_r;
    reg  [7:0] holdSec_r;
    reg        failed_r;
    wire       priFaultTimed = chFault[0] & (failSec_r >= failTime_r);
    wire       priHeld       = ~chFault[0] & (holdSec_r >= resetTime_r);

    // counters saturate; the opposite condition clears each at once
    // a zero time acts on the first qualifying cycle; saturation keeps a
    // long outage from wrapping round and looking like a fresh one
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            failSec_r <= 8'h00;
            holdSec_r <= 8'h00;
            failed_r  <= 1'b0;
        end
        else
        begin
            if (!chFault[0])
                failSec_r <= 8'h00;
            else if (tick && failSec_r != 8'hFF)
                failSec_r <= failSec_r + 8'h01;
            if (chFault[0])
                holdSec_r <= 8'h00;
            else if (tick && holdSec_r != 8'hFF)
                holdSec_r <= holdSec_r + 8'h01;
            // remember a timed fault so a return needs a real recovery
            if (priFaultTimed)
                failed_r <= 1'b1;
            else if (priHeld)
                failed_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switch position

    reg  selSec_r;
    reg  selSec_nxt;
    wire autoMove;
    wire autoBack;

    // failover needs a timed primary fault, auto on and a clean secondary
    assign autoMove = ~selSec_r & autoOn & priFaultTimed & ~chFault[1];
    // return needs auto return, a recorded fault and a full healthy hold
    assign autoBack = selSec_r & aretOn & failed_r & priHeld;

    // manual requests beat automatic moves; primary command wins a tie
    always @*
    begin
        selSec_nxt = selSec_r;
        if (cmdPri_r || priFall)
            selSec_nxt = 1'b0;
        else if (cmdSec_r || secFall)
            selSec_nxt = 1'b1;
        else if (autoMove)
            selSec_nxt = 1'b1;
        else if (autoBack)
            selSec_nxt = 1'b0;
    end

    // reset lands on primary, the safe resting position of the switch
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            selSec_r <= 1'b0;
        else
            selSec_r <= selSec_nxt;
    end

    assign selSecondary = selSec_r;
    assign priLedGreen  = ~selSec_r;
    assign secLedRed    = selSec_r;
    assign autoLedGreen = autoOn;

    assign statusWord = {23'h00_0000, trigStat[3:2], trigStat[1:0],
                         overall[3:2], overall[1:0], selSec_r};

endmodule

`default_nettype wire

// File: tb/psc_switch_properties.sv
// port assertions for the protection switch control block
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.vh"
module psc_switch_properties (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [3:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic        avsWaitRequest,
    input wire logic        selSecondary,
    input wire logic        priLedGreen,
    input wire logic        secLedRed,
    input wire logic [1:0]  priOverall,
    input wire logic [1:0]  priTrigStatus
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    // a request is taken in its first cycle, command writes ride on it
    sequence taken_s;
        (avsRead || avsWrite) && avsWaitRequest;
    endsequence
    sequence cmd_s;
        taken_s ##0 avsWrite && avsAddress == `PSC_OFS_CMD;
    endsequence
    wait_one_a: assert property (taken_s |=> !avsWaitRequest)
        else $error("waitrequest held past one cycle");
    req_wait_a: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest)
        else $error("new request answered without a wait");
    pri_cmd_a: assert property (cmd_s ##0 avsWriteData[0] |-> ##[1:2] !selSecondary)
        else $error("primary command did not route primary");
    sec_cmd_a: assert property (cmd_s ##0 avsWriteData[1:0] == 2'b10 |-> ##[1:2] selSecondary)
        else $error("secondary command did not route secondary");
    pri_led_a: assert property (priLedGreen == !selSecondary)
        else $error("primary indicator wrong");
    sec_led_a: assert property (secLedRed == selSecondary)
        else $error("secondary indicator wrong");
    fail_bad_a: assert property (priTrigStatus != `PSC_TS_GOOD |-> priOverall == `PSC_OV_BAD)
        else $error("failing test but overall not bad");
    good_ok_a: assert property (priTrigStatus == `PSC_TS_GOOD |-> priOverall != `PSC_OV_BAD)
        else $error("passing tests but overall bad");
    reset_pri_a: assert property ($rose(resetn) |-> !selSecondary)
        else $error("secondary selected out of reset");
endmodule
`default_nettype wire

// File: tb/psc_far_end.sv
// far side model: signal detectors and external trigger equipment
`timescale 1ns/1ps
`default_nettype none
module psc_far_end (
    input wire logic       clk,
    input wire logic       slow,
    input wire logic [3:0] want,
    output logic           priSigOk,
    output logic           secSigOk,
    output logic           priTrigIn,
    output logic           secTrigIn
);
    logic [3:0] stage_r = 4'hF;
    logic [3:0] out_r = 4'hF;
    // slow equipment adds a stage; pins are async to the block anyway
    always @(posedge clk)
    begin
        stage_r <= want;
        out_r <= slow ? stage_r : want;
    end
    assign {priSigOk, secSigOk, priTrigIn, secTrigIn} = out_r;
endmodule
`default_nettype wire

// File: tb/test_protection_switch_control.sv
// self-checking bench for the protection switch control block
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_protection_switch_control;
    logic clk, resetn, avsRead, avsWrite, avsWaitRequest, selSecondary, slow, es, ea;
    logic priSigOk, secSigOk, priTrigIn, secTrigIn, priLedGreen, secLedRed, autoLedGreen;
    logic [3:0] avsAddress, avsByteEnable, want;
    logic [31:0] avsWriteData, avsReadData, q, d;
    logic [1:0] priOverall, secOverall, priTrigStatus, secTrigStatus;
    int err_count = 0, num_checks = 0, cycles = 0;
    psc_protection_switch_control #(.TICK_CYCLES(10)) uut (.clk(clk), .resetn(resetn),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .priSigOk(priSigOk), .secSigOk(secSigOk), .priTrigIn(priTrigIn), .secTrigIn(secTrigIn),
        .selSecondary(selSecondary), .priLedGreen(priLedGreen), .secLedRed(secLedRed),
        .autoLedGreen(autoLedGreen), .priOverall(priOverall), .secOverall(secOverall),
        .priTrigStatus(priTrigStatus), .secTrigStatus(secTrigStatus));
    psc_far_end far (.clk(clk), .slow(slow), .want(want), .priSigOk(priSigOk), .secSigOk(secSigOk),
        .priTrigIn(priTrigIn), .secTrigIn(secTrigIn));
    ////////////////////////////////////////////////////////////////
    // clock and hang guard; the run needs under a thousand cycles
    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            err_count++;
            print_verdict();
        end
    end
    task print_verdict();
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one avalon transfer: hold until waitrequest is seen low at an edge
    task xfer(input logic wr, input logic [3:0] a, input logic [31:0] dt, output logic [31:0] rq);
        int n;
        n = 0;
        @(posedge clk);
        avsAddress <= a; avsWriteData <= dt; avsWrite <= wr; avsRead <= !wr;
        // waitrequest and read data are read at the edge, before that edge updates them
        do begin @(posedge clk); n++; end
        while (avsWaitRequest !== 1'b0 && n < 50);
        rq = avsReadData;
        if (avsWaitRequest !== 1'b0) err_count++;
        avsWrite <= 0; avsRead <= 0;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] dt);
        logic [31:0] x;
        xfer(1'b1, a, dt, x);
    endtask
    task hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    task waitSel(input logic v, input int maxc);
        int n;
        n = 0;
        while (selSecondary !== v && n < maxc) begin @(negedge clk); n++; end
        `CHK(selSecondary, v)
    endtask
    // primary wins over secondary, otherwise position is kept
    function logic expSel(input logic [31:0] c, input logic prev);
        return c[0] ? 1'b0 : (c[1] ? 1'b1 : prev);
    endfunction
    ////////////////////////////////////////////////////////////////
    initial
    begin
        resetn = 0; avsRead = 0; avsWrite = 0; avsAddress = 0; avsWriteData = 0;
        avsByteEnable = 4'hF; want = 4'hF; slow = 0;
        void'($urandom(32'h8b24ae02));
        repeat (3) @(posedge clk);
        resetn <= 1;
        xfer(0, `PSC_OFS_CTRL, 0, q); `CHK(q[7:0], `PSC_CTRL_RST)
        xfer(0, `PSC_OFS_TIME, 0, q); `CHK(q[15:0], {`PSC_RESET_RST, `PSC_FAIL_RST})
        xfer(0, 4'h1, 0, q); `CHK(q, 32'h0000_0000)
        `CHK(selSecondary, 1'b0)
        wr(`PSC_OFS_TIME, 32'h0000_0502);
        hold(4); `CHK(priTrigStatus, `PSC_TS_GOOD) `CHK(priOverall, `PSC_OV_GOOD)
        wr(`PSC_OFS_CMD, 2); waitSel(1, 4); `CHK(secLedRed, 1'b1)
        wr(`PSC_OFS_CMD, 1); waitSel(0, 4); `CHK(priLedGreen, 1'b1)
        wr(`PSC_OFS_CTRL, 3); want[3] <= 0; slow <= 1; hold(40);
        `CHK(priOverall, `PSC_OV_NONE) `CHK(priTrigStatus, `PSC_TS_GOOD) `CHK(selSecondary, 1'b0)
        `CHK(secOverall, `PSC_OV_NONE)
        wr(`PSC_OFS_CTRL, 7); hold(2); `CHK(priTrigStatus, `PSC_TS_DETFAIL)
        hold(4); `CHK(selSecondary, 1'b0)
        waitSel(1, 40);
        want[3] <= 1; hold(30); want[3] <= 0; hold(4); want[3] <= 1; hold(32);
        `CHK(selSecondary, 1'b1)
        waitSel(0, 100);
        wr(`PSC_OFS_CMD, 4); hold(2); `CHK(autoLedGreen, 1'b0)
        want[3] <= 0; hold(50); `CHK(selSecondary, 1'b0) `CHK(priOverall, `PSC_OV_BAD)
        want[3] <= 1; hold(8); wr(`PSC_OFS_CMD, 4); hold(2); `CHK(autoLedGreen, 1'b1)
        want[3:2] <= 0; hold(50); `CHK(selSecondary, 1'b0) `CHK(secOverall, `PSC_OV_BAD)
        want[3:2] <= 3; slow <= 0; hold(8);
        wr(`PSC_OFS_CTRL, 5); want[3] <= 0; waitSel(1, 50);
        want[3] <= 1; hold(80); `CHK(selSecondary, 1'b1)
        wr(`PSC_OFS_CMD, 1); waitSel(0, 4);
        wr(`PSC_OFS_CTRL, 32'h0000_002F); want[0] <= 0; waitSel(1, 8);
        want[1] <= 0; waitSel(0, 8);
        wr(`PSC_OFS_CMD, 2); hold(10); `CHK(selSecondary, 1'b1)
        want[1:0] <= 3; wr(`PSC_OFS_CMD, 1); waitSel(0, 4);
        wr(`PSC_OFS_CTRL, 7); want[0] <= 0; hold(10);
        `CHK(selSecondary, 1'b0) `CHK(secTrigStatus, `PSC_TS_GOOD)
        want[0] <= 1; wr(`PSC_OFS_CTRL, 32'h0000_0017); want[1] <= 0; hold(6);
        `CHK(priTrigStatus, `PSC_TS_EXTFAIL)
        waitSel(1, 40);
        want[3] <= 0; hold(6); `CHK(priTrigStatus, `PSC_TS_BOTHFAIL)
        want[3] <= 1; want[1] <= 1; hold(6); wr(`PSC_OFS_CMD, 1); waitSel(0, 4);
        wr(`PSC_OFS_CTRL, 5); es = 0; ea = 1;
        repeat (24)
        begin
            d = $urandom & 7;
            wr(`PSC_OFS_CMD, d); hold(2);
            es = expSel(d, es); ea = ea ^ d[2];
            `CHK(selSecondary, es) `CHK(autoLedGreen, ea)
            d = $urandom & 32'h0000_FFFF;
            wr(`PSC_OFS_TIME, d); xfer(0, `PSC_OFS_TIME, 0, q); `CHK(q[15:0], d[15:0])
        end
        // second reset in mid-run, taken while secondary is routed
        wr(`PSC_OFS_CMD, 2); waitSel(1, 4);
        @(posedge clk) resetn <= 0;
        repeat (3) @(posedge clk);
        resetn <= 1;
        `CHK(selSecondary, 1'b0) `CHK(priLedGreen, 1'b1)
        xfer(0, `PSC_OFS_TIME, 0, q); `CHK(q[15:0], {`PSC_RESET_RST, `PSC_FAIL_RST})
        print_verdict();
    end
endmodule
bind psc_protection_switch_control psc_switch_properties chk (.clk(clk), .resetn(resetn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsWaitRequest(avsWaitRequest), .selSecondary(selSecondary), .priLedGreen(priLedGreen),
    .secLedRed(secLedRed), .priOverall(priOverall), .priTrigStatus(priTrigStatus));
`default_nettype wire
